// ==== shared/tzsc_pkg.sv ====
// tzsc_pkg: register map, field positions, reset values, timing and carrier types
// for the three-zone temperature scan controller.
// assumes a 20 MHz device clock and a framing layer that presents decoded accesses.
`default_nettype none
package tzsc_pkg;
   // register addresses on the serial bus (6-bit space)
   localparam logic [5:0]  ADDR_CAPS_FIXED   = 6'h03; // device capability descriptor
   localparam logic [5:0]  ADDR_DEV_STATUS   = 6'h04; // event, error and bus error flags
   localparam logic [5:0]  ADDR_DEV_CONTROL  = 6'h05; // reset, shutdown, low power, enable
   localparam logic [5:0]  ADDR_TEMP_CAPS    = 6'h08; // readout format descriptor
   localparam logic [5:0]  ADDR_TEMP_CONTROL = 6'h09; // zone scan enables, attention enable
   localparam logic [5:0]  ADDR_READOUT      = 6'h0a; // latest result and its zone

   // device control fields
   localparam int          CTL_RESET_BIT     = 0;
   localparam int          CTL_SHUTDOWN_BIT  = 1;
   localparam int          CTL_LOW_POWER_BIT = 2;
   localparam int          CTL_ENABLE_BIT    = 4;
   localparam logic [15:0] CTL_RESET_VAL     = 16'h0000;

   // device status fields
   localparam int          STS_EVENT_BIT     = 0;
   localparam int          STS_ERROR_BIT     = 4;
   localparam int          STS_BUS_ERR_BIT   = 7;
   localparam logic [15:0] STS_RESET_VAL     = 16'h0000;

   // temperature control fields: zone enables at [2:0], attention enable
   localparam int          TCTL_ZONE_LSB     = 0;
   localparam int          TCTL_ATTN_BIT     = 3;
   localparam logic [3:0]  TCTL_RESET_VAL    = 4'h7;

   // readout fields: 10-bit signed value at [15:6], zone number at [1:0]
   localparam int          RD_TEMP_LSB       = 6;
   localparam int          RD_ZONE_LSB       = 0;
   localparam logic [15:0] READOUT_RESET_VAL = 16'h0000;

   // fixed descriptors
   localparam logic [3:0]  FUNC_TYPE_CODE    = 4'h1;     // temperature measurement type
   localparam logic [15:0] TEMP_CAPS_VAL     = 16'h0549; // signed, 10 bits, half degree
   localparam logic [2:0]  RESOLUTION_CODE   = 3'h1;     // lsb weight of half a degree

   // zone numbering
   localparam int          NUM_ZONES         = 3;
   localparam logic [1:0]  ZONE_LOCAL        = 2'h0;     // on-die sensor

   // timing
   localparam int          CLK_MHZ           = 20;
   localparam int          ZONE_PERIOD_US    = 50000;    // active-mode time per zone
   localparam int          ZONE_CYCLES       = ZONE_PERIOD_US * CLK_MHZ;
   localparam int          LOW_POWER_FACTOR  = 4;        // low power slows the scan this much
   localparam int          RESET_OP_CYCLES   = 4;        // length of a device reset operation

   // one decoded register access from the framing layer
   typedef struct packed {
      logic       wr;        // write strobe, one cycle
      logic       rd;        // read strobe, one cycle
      logic       broadcast; // write came to device number zero
      logic [5:0] addr;      // register address
      logic [15:0] wdata;    // write data
   } tzsc_req_t;

   // request to and answer from the analog converter
   typedef struct packed {
      logic       start;     // one-cycle start of a conversion
      logic [1:0] zone;      // zone to convert
   } tzsc_conv_req_t;

   typedef struct packed {
      logic       done;      // one-cycle result strobe
      logic [9:0] temp;      // signed two's complement, half-degree lsb
   } tzsc_conv_rsp_t;
endpackage : tzsc_pkg
`default_nettype wire

// ==== hw/tzsc_scan_timer.sv ====
// tzsc_scan_timer: paces the zone scan, one tick per zone period.
// assumes restart is raised whenever the scan must begin a fresh period.
`default_nettype none
module tzsc_scan_timer #(
   parameter int unsigned ZONE_CYCLES = tzsc_pkg::ZONE_CYCLES,
   parameter int unsigned LP_FACTOR   = tzsc_pkg::LOW_POWER_FACTOR
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic run,       // count only while the scan is running
   input  wire logic restart,   // begin a fresh period
   input  wire logic low_power, // stretch the period
   output logic      tick       // one-cycle end of a period
);
   localparam int W = $clog2(ZONE_CYCLES * LP_FACTOR + 1);

   // refuse periods the counter cannot represent, at elaboration rather than at run time
   if (ZONE_CYCLES < 1 || LP_FACTOR < 1) begin : g_bad_period
      $error("tzsc_scan_timer: periods must be at least one cycle");
   end

   logic [W-1:0] count;        // cycles spent in the current period
   logic [W-1:0] limit;        // last count of the period

   // low power stretches the period rather than skipping ticks, so spacing stays even
   assign limit = low_power ? W'(ZONE_CYCLES * LP_FACTOR - 1) : W'(ZONE_CYCLES - 1);

   // period counter; tick registered so the sequencer sees a clean pulse
   always_ff @(posedge clk) begin
      if (srst) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (ce) begin
         tick <= 1'b0;
         if (restart || !run) begin
            count <= '0;
         end else if (count >= limit) begin
            count <= '0;
            tick  <= 1'b1;
         end else begin
            count <= count + W'(1);
         end
      end
   end
endmodule : tzsc_scan_timer
`default_nettype wire

// ==== hw/tzsc_top.sv ====
// tzsc_top: device control, status and temperature scan function of a three-zone sensor.
// assumes the bus framing layer decodes accesses into req, all on clk, and an
// analog converter that answers each start with exactly one done strobe.
`default_nettype none
module tzsc_top #(
   parameter int unsigned ZONE_CYCLES = tzsc_pkg::ZONE_CYCLES
) (
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic                     ce,
   input  wire tzsc_pkg::tzsc_req_t      req,       // decoded register access
   input  wire logic                     nack,      // transaction ended without ack
   output logic [15:0]                   rdata,     // read data, one cycle after rd
   output logic                          rvalid,    // read data valid
   output tzsc_pkg::tzsc_conv_req_t      conv_req,  // converter start and zone
   input  wire tzsc_pkg::tzsc_conv_rsp_t conv_rsp,  // converter result
   output logic                          attn_req,  // attention request pulse
   output logic                          low_power  // analog side low power level
);
   typedef enum logic [1:0] {TZSC_IDLE, TZSC_WAIT, TZSC_CONV} tzsc_state_t;

   // ascending round-robin pick of the next enabled zone after cur
   function automatic logic [1:0] tzsc_next_zone(input logic [1:0] cur,
                                                 input logic [2:0] en);
      logic [1:0] z;
      z = cur;
      for (int i = 0; i < tzsc_pkg::NUM_ZONES; i++) begin
         z = (z == 2'h2) ? 2'h0 : z + 2'h1;
         if (en[z])
            return z;
      end
      return cur;
   endfunction : tzsc_next_zone

   // control state
   logic              shutdown;     // all functions halted
   logic              func_enable;  // temperature function enabled
   logic              reset_busy;   // device reset operation running
   logic [2:0]        reset_cnt;    // cycles left in the reset operation
   logic              soft_clear;   // last cycle of the reset operation
   // function state
   logic [2:0]        zone_en;      // per-zone scan enables
   logic              attn_enable;  // attention request enable
   logic              event_flag;   // function event flag
   logic              error_flag;   // function error flag (overrun)
   logic              bus_err;      // bus error flag
   logic [15:0]       readout;      // latest result
   tzsc_state_t       state;        // sequencer state
   logic [1:0]        zone;         // zone under measurement
   logic              run;          // scan may proceed
   logic              tick;         // zone period elapsed
   logic              new_result;   // result accepted this cycle
   // decoded accesses
   logic              wr_ctl;
   logic              wr_tctl;
   logic              rd_sts;
   logic              rd_out;
   logic [15:0]       ctl_view;

   // address decode; broadcast reaches only the device control register
   always_comb begin
      wr_ctl  = 1'b0;
      wr_tctl = 1'b0;
      rd_sts  = 1'b0;
      rd_out  = 1'b0;
      if (req.wr && req.addr == tzsc_pkg::ADDR_DEV_CONTROL) begin
         wr_ctl = 1'b1;
      end else if (req.wr && !req.broadcast && req.addr == tzsc_pkg::ADDR_TEMP_CONTROL) begin
         wr_tctl = 1'b1;
      end else if (req.rd && req.addr == tzsc_pkg::ADDR_DEV_STATUS) begin
         rd_sts = 1'b1;
      end else if (req.rd && req.addr == tzsc_pkg::ADDR_READOUT) begin
         rd_out = 1'b1;
      end
   end

   assign soft_clear = reset_busy && reset_cnt == 3'h1;
   assign low_power  = ctl_view[tzsc_pkg::CTL_LOW_POWER_BIT] && !shutdown;
   // no scan while disabled, shut down, resetting or with no zone selected
   assign run = func_enable && !shutdown && !reset_busy && |zone_en;
   assign new_result = run && state == TZSC_CONV && conv_rsp.done;

   // device reset operation: a write of one to bit 0 runs a short timed sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         reset_busy <= 1'b0;
         reset_cnt  <= '0;
      end else if (ce) begin
         if (reset_busy) begin
            reset_cnt <= reset_cnt - 3'h1;
            if (reset_cnt == 3'h1)
               reset_busy <= 1'b0;
         end else if (wr_ctl && req.wdata[tzsc_pkg::CTL_RESET_BIT]) begin
            reset_busy <= 1'b1;
            reset_cnt  <= 3'(tzsc_pkg::RESET_OP_CYCLES);
         end
      end
   end

   // device control bits; unimplemented bits have no storage
   logic low_power_sel;
   always_ff @(posedge clk) begin
      if (srst || (ce && soft_clear)) begin
         shutdown      <= tzsc_pkg::CTL_RESET_VAL[tzsc_pkg::CTL_SHUTDOWN_BIT];
         low_power_sel <= tzsc_pkg::CTL_RESET_VAL[tzsc_pkg::CTL_LOW_POWER_BIT];
         func_enable   <= tzsc_pkg::CTL_RESET_VAL[tzsc_pkg::CTL_ENABLE_BIT];
      end else if (ce && wr_ctl && !reset_busy) begin
         shutdown <= req.wdata[tzsc_pkg::CTL_SHUTDOWN_BIT];
         // broadcast writes leave the upper bits alone
         if (!req.broadcast) begin
            low_power_sel <= req.wdata[tzsc_pkg::CTL_LOW_POWER_BIT];
            func_enable   <= req.wdata[tzsc_pkg::CTL_ENABLE_BIT];
         end
      end
   end

   // control read view; bits 3 and 15-5 are constant zero
   always_comb begin
      ctl_view = '0;
      ctl_view[tzsc_pkg::CTL_RESET_BIT]     = reset_busy;
      ctl_view[tzsc_pkg::CTL_SHUTDOWN_BIT]  = shutdown;
      ctl_view[tzsc_pkg::CTL_LOW_POWER_BIT] = low_power_sel;
      ctl_view[tzsc_pkg::CTL_ENABLE_BIT]    = func_enable;
   end

   // temperature control; default enables every zone so no setup is needed
   always_ff @(posedge clk) begin
      if (srst || (ce && soft_clear)) begin
         zone_en     <= tzsc_pkg::TCTL_RESET_VAL[2:0];
         attn_enable <= tzsc_pkg::TCTL_RESET_VAL[tzsc_pkg::TCTL_ATTN_BIT];
      end else if (ce && wr_tctl) begin
         // writable whether or not the function is enabled
         zone_en     <= req.wdata[tzsc_pkg::TCTL_ZONE_LSB +: 3];
         attn_enable <= req.wdata[tzsc_pkg::TCTL_ATTN_BIT];
      end
   end

   // pacing of the zone scan
   tzsc_scan_timer #(
      .ZONE_CYCLES (ZONE_CYCLES),
      .LP_FACTOR   (tzsc_pkg::LOW_POWER_FACTOR)
   ) u_timer (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .run       (run && state == TZSC_WAIT),
      .restart   (state == TZSC_IDLE),
      .low_power (low_power),
      .tick      (tick)
   );

   // scan sequencer: wait a period, convert the zone, move to the next enabled zone
   always_ff @(posedge clk) begin
      if (srst || (ce && soft_clear)) begin
         state         <= TZSC_IDLE;
         zone          <= tzsc_pkg::ZONE_LOCAL;
         conv_req      <= '0;
      end else if (ce) begin
         conv_req.start <= 1'b0;
         if (!run) begin
            // leaving the scan forgets the position, so it restarts from the bottom
            state <= TZSC_IDLE;
         end else begin
            case (state)
               TZSC_IDLE: begin
                  // lowest enabled zone: search onward from the top zone
                  zone  <= tzsc_next_zone(2'h2, zone_en);
                  state <= TZSC_WAIT;
               end
               TZSC_WAIT: begin
                  if (!zone_en[zone]) begin
                     // zone switched off while waiting: skip it at once
                     zone <= tzsc_next_zone(zone, zone_en);
                  end else if (tick) begin
                     conv_req.start <= 1'b1;
                     conv_req.zone  <= zone;
                     state          <= TZSC_CONV;
                  end
               end
               TZSC_CONV: begin
                  if (conv_rsp.done) begin
                     zone  <= tzsc_next_zone(zone, zone_en);
                     state <= TZSC_WAIT;
                  end
               end
               default: begin
                  state <= TZSC_IDLE;
               end
            endcase
         end
      end
   end

   // readout: value passed through unchanged in its fixed signed format
   always_ff @(posedge clk) begin
      if (srst || (ce && soft_clear)) begin
         readout <= tzsc_pkg::READOUT_RESET_VAL;
      end else if (ce && new_result) begin
         // overwritten even if unread; the error flag records the loss
         readout <= '0;
         readout[tzsc_pkg::RD_TEMP_LSB +: 10] <= conv_rsp.temp;
         readout[tzsc_pkg::RD_ZONE_LSB +: 2]  <= zone;
      end
   end

   // event and overrun flags: a result in the same cycle as a read sets the event flag and clears the overrun flag
   always_ff @(posedge clk) begin
      if (srst || (ce && soft_clear)) begin
         event_flag <= tzsc_pkg::STS_RESET_VAL[tzsc_pkg::STS_EVENT_BIT];
         error_flag <= tzsc_pkg::STS_RESET_VAL[tzsc_pkg::STS_ERROR_BIT];
      end else if (ce) begin
         if (new_result) begin
            event_flag <= 1'b1;
         end else if (rd_out) begin
            event_flag <= 1'b0;
         end
         // overrun only if the previous result is still unread after this cycle
         if (new_result && event_flag && !rd_out) begin
            error_flag <= 1'b1;
         end else if (rd_out) begin
            error_flag <= 1'b0;
         end
      end
   end

   // bus error flag; a nack beside a status read wins
   always_ff @(posedge clk) begin
      if (srst || (ce && soft_clear)) begin
         bus_err <= tzsc_pkg::STS_RESET_VAL[tzsc_pkg::STS_BUS_ERR_BIT];
      end else if (ce) begin
         if (nack) begin
            bus_err <= 1'b1;
         end else if (rd_sts) begin
            bus_err <= 1'b0;
         end
      end
   end

   // attention request follows each event, gated by its enable
   always_ff @(posedge clk) begin
      if (srst) begin
         attn_req <= 1'b0;
      end else if (ce) begin
         attn_req <= new_result && attn_enable;
      end
   end

   // read data register; unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata  <= '0;
         rvalid <= 1'b0;
      end else if (ce) begin
         rvalid <= req.rd;
         rdata  <= '0;
         if (req.rd) begin
            if (req.addr == tzsc_pkg::ADDR_CAPS_FIXED) begin
               rdata <= {12'h000, tzsc_pkg::FUNC_TYPE_CODE};
            end else if (req.addr == tzsc_pkg::ADDR_DEV_STATUS) begin
               rdata[tzsc_pkg::STS_EVENT_BIT]   <= event_flag;
               rdata[tzsc_pkg::STS_ERROR_BIT]   <= error_flag;
               rdata[tzsc_pkg::STS_BUS_ERR_BIT] <= bus_err;
            end else if (req.addr == tzsc_pkg::ADDR_DEV_CONTROL) begin
               rdata <= ctl_view;
            end else if (req.addr == tzsc_pkg::ADDR_TEMP_CAPS) begin
               rdata <= tzsc_pkg::TEMP_CAPS_VAL;
            end else if (req.addr == tzsc_pkg::ADDR_TEMP_CONTROL) begin
               rdata[tzsc_pkg::TCTL_ZONE_LSB +: 3] <= zone_en;
               rdata[tzsc_pkg::TCTL_ATTN_BIT]      <= attn_enable;
            end else if (req.addr == tzsc_pkg::ADDR_READOUT) begin
               rdata <= readout;
            end
         end
      end
   end
endmodule : tzsc_top
`default_nettype wire

// ==== verif/tzsc_checker.sv ====
// tzsc_checker: port-level temporal checks on the temperature scan controller.
// assumes it is bound to tzsc_top, sees only its ports, and ce drops only while idle.
`default_nettype none
module tzsc_checker #(
   parameter int unsigned ZONE_CYCLES = 8 // zone period handed on from the top
) (
   input wire logic                     clk,
   input wire logic                     srst,
   input wire logic                     ce,
   input wire tzsc_pkg::tzsc_req_t      req,
   input wire logic                     nack,
   input wire logic [15:0]              rdata,
   input wire logic                     rvalid,
   input wire tzsc_pkg::tzsc_conv_req_t conv_req,
   input wire tzsc_pkg::tzsc_conv_rsp_t conv_rsp,
   input wire logic                     attn_req,
   input wire logic                     low_power
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // every read is answered on the next cycle, enabled function or not
   property p_rd_ans; ce && req.rd |=> rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   // unimplemented control bits never read back as one
   property p_ctl_res; rvalid && $past(req.addr) == 6'h05 |-> rdata[15:5] == 11'h0 && !rdata[3];
   endproperty
   a_ctl_res: assert property (p_ctl_res) else $error("control reserved bit set");
   // capability descriptor reports the temperature function type
   property p_caps; rvalid && $past(req.addr) == 6'h03 |-> rdata == 16'h0001; endproperty
   a_caps: assert property (p_caps) else $error("function type wrong");
   // half-degree resolution code and signed format are fixed
   property p_tcaps; rvalid && $past(req.addr) == 6'h08 |-> rdata[2:0] == 3'h1 && rdata[6];
   endproperty
   a_tcaps: assert property (p_tcaps) else $error("format descriptor wrong");
   // readout carries a zone of zero to two and no optional fields
   property p_ro_zone;
      rvalid && $past(req.addr) == 6'h0a |-> rdata[1:0] != 2'h3 && rdata[5:2] == 4'h0;
   endproperty
   a_ro_zone: assert property (p_ro_zone) else $error("readout zone field bad");
   // attention only follows a stored result
   property p_attn; attn_req |-> $past(conv_rsp.done); endproperty
   a_attn: assert property (p_attn) else $error("attention without result");
   // only the three real zones are ever converted
   property p_zone; conv_req.start |-> conv_req.zone != 2'h3; endproperty
   a_zone: assert property (p_zone) else $error("zone out of range");
   // shutdown drops the analog side out of low power into its lowest state
   property p_sd; ce && req.wr && req.addr == 6'h05 && req.wdata[1] |=> !low_power; endproperty
   a_sd: assert property (p_sd) else $error("low power during shutdown");
   // low power bit alone reaches the analog side on the next cycle
   property p_lp;
      ce && req.wr && !req.broadcast && req.addr == 6'h05 && req.wdata[2:0] == 3'h4 |=> low_power;
   endproperty
   a_lp: assert property (p_lp) else $error("low power not applied");
   // disabling the function, with shutdown also set, stops new conversions for eight cycles
   property p_dis;
      ce && req.wr && !req.broadcast && req.addr == 6'h05 && req.wdata[4:0] == 5'h0e
      |=> ##1 (!conv_req.start) [*8];
   endproperty
   a_dis: assert property (p_dis) else $error("conversion while disabled");
   // cycles since the last conversion start, saturating at the zone period
   int unsigned since_start;
   always_ff @(posedge clk) begin
      if (srst || conv_req.start) begin
         since_start <= '0;
      end else if (ce && since_start < ZONE_CYCLES) begin
         since_start <= since_start + 32'd1;
      end
   end
   // starts are spaced by at least one full zone period
   property p_gap; conv_req.start |-> since_start >= ZONE_CYCLES; endproperty
   a_gap: assert property (p_gap) else $error("conversion starts too close");
endmodule : tzsc_checker
bind tzsc_top tzsc_checker #(.ZONE_CYCLES(ZONE_CYCLES)) u_tzsc_checker (
   .clk(clk), .srst(srst), .ce(ce), .req(req), .nack(nack), .rdata(rdata),
   .rvalid(rvalid), .conv_req(conv_req), .conv_rsp(conv_rsp), .attn_req(attn_req),
   .low_power(low_power));
`default_nettype wire

// ==== verif/tzsc_conv_model.sv ====
// tzsc_conv_model: behavioural analog converter, one done per start.
// assumes lat sets the conversion time and temps holds the result of each zone.
`default_nettype none
module tzsc_conv_model (
   input wire logic                     clk,
   input wire logic                     srst,
   input wire tzsc_pkg::tzsc_conv_req_t conv_req,
   input wire logic [7:0]               lat,
   input wire logic [2:0][9:0]          temps,
   output tzsc_pkg::tzsc_conv_rsp_t     conv_rsp
);
   logic [7:0] cnt;  // cycles left in the conversion
   logic       busy; // conversion in flight
   logic [1:0] zone; // zone being converted
   // result bus toggles outside the done cycle so a sample taken one cycle late does not match
   always_ff @(posedge clk) begin
      if (srst) begin
         busy     <= 1'b0;
         conv_rsp <= '0;
      end else begin
         conv_rsp.done <= 1'b0;
         conv_rsp.temp <= ~conv_rsp.temp;
         if (conv_req.start) begin
            busy <= 1'b1;
            cnt  <= lat;
            zone <= conv_req.zone;
         end else if (busy && cnt == 8'h00) begin
            busy     <= 1'b0;
            conv_rsp <= '{done: 1'b1, temp: temps[zone]};
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule : tzsc_conv_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// tb_top: self-checking bench for the temperature scan controller.
// assumes a 20 MHz clock and a shortened zone period; the converter is modelled.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // shortened zone period; the full default of a million cycles per zone would outlast the watchdog
   localparam int            ZC = 20;
   logic                     clk = 1'b0;
   logic                     ce = 1'b1;                // dropped once to check the freeze
   logic                     srst = 1'b1;
   tzsc_pkg::tzsc_req_t      req = '0;                 // register access
   logic                     nack = 1'b0;
   logic [15:0]              rdata;
   logic                     rvalid;
   tzsc_pkg::tzsc_conv_req_t conv_req;
   tzsc_pkg::tzsc_conv_rsp_t conv_rsp;
   logic                     attn_req;
   logic                     low_power;
   logic [2:0][9:0]          temps = {10'h3f6, 10'h0a5, 10'h032}; // zone 2 is negative
   int                       err_count = 0;
   int                       checks = 0;
   int                       nattn = 0, nstart = 0, cyc = 0, t0 = 0, gap = 0, sa, sl, n0;
   logic [15:0]              d;                        // last read data
   // after-reset reads: address beside expected value, unmapped address last
   logic [21:0]              rows [7] = '{{6'h03, 16'h0001}, {6'h04, 16'h0000},
      {6'h05, 16'h0000}, {6'h08, 16'h0549}, {6'h09, 16'h0007}, {6'h0a, 16'h0000},
      {6'h3f, 16'h0000}};
   tzsc_top #(.ZONE_CYCLES(ZC)) u_tzsc_top (.clk(clk), .srst(srst), .ce(ce), .req(req),
      .nack(nack), .rdata(rdata), .rvalid(rvalid), .conv_req(conv_req),
      .conv_rsp(conv_rsp), .attn_req(attn_req), .low_power(low_power));
   tzsc_conv_model u_tzsc_conv_model (.clk(clk), .srst(srst), .conv_req(conv_req),
      .lat(8'h03), .temps(temps), .conv_rsp(conv_rsp));
   always #25 clk = ~clk;
   // count attention pulses and measure the spacing of conversion starts
   always @(posedge clk) begin
      cyc++;
      if (attn_req) nattn++;
      if (conv_req.start) begin
         nstart++;
         gap = cyc - t0;
         t0  = cyc;
      end
   end
   function automatic logic [15:0] ro(input int z);
      return {temps[z], 4'h0, 2'(z)};
   endfunction : ro
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] v, input logic b);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, broadcast: b, addr: a, wdata: v};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, broadcast: 1'b0, addr: a, wdata: 16'h0000};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
      chk({15'h0, rvalid}, 16'h0001);
   endtask : rd
   task automatic rc(input logic [5:0] a, input logic [15:0] e);
      rd(a);
      chk(d, e);
   endtask : rc
   // bounded wait for the next attention pulse
   task automatic wait_attn;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (attn_req !== 1'b1 && n < 400);
      chk(16'(n < 400), 16'h0001);
   endtask : wait_attn
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) rc(rows[i][21:16], rows[i][15:0]);
      // zones 0 and 2 with attention, enabled with no other setup
      wr(6'h09, 16'h000d, 1'b0);
      wr(6'h05, 16'h0010, 1'b0);
      for (int k = 0; k < 3; k++) begin
         wait_attn;
         if (k == 0) rc(6'h04, 16'h0001);
         rc(6'h0a, ro(k[0] ? 2 : 0));
      end
      rc(6'h04, 16'h0000);
      wait_attn;
      wait_attn;
      rc(6'h04, 16'h0011);
      rc(6'h0a, ro(0));
      rc(6'h04, 16'h0000);
      // zone 1 only, attention off
      wr(6'h09, 16'h0002, 1'b0);
      n0 = nattn;
      repeat (100) @(posedge clk);
      chk(16'(nattn - n0), 16'h0000);
      rc(6'h0a, ro(1));
      // low power stretches the scan
      sa = gap;
      wr(6'h05, 16'h0014, 1'b0);
      repeat (300) @(posedge clk);
      sl = gap;
      #1 chk({15'h0, low_power}, 16'h0001);
      chk(16'(sl >= 4 * ZC && sa < 2 * ZC), 16'h0001);
      // broadcast shutdown touches only the low two bits
      wr(6'h05, 16'hfffe, 1'b1);
      rc(6'h05, 16'h0016);
      chk({15'h0, low_power}, 16'h0000);
      n0 = nstart;
      repeat (200) @(posedge clk);
      chk(16'(nstart - n0), 16'h0000);
      wr(6'h05, 16'h0000, 1'b1);
      rc(6'h05, 16'h0014);
      wr(6'h05, 16'hffee, 1'b0);
      rc(6'h05, 16'h0006);
      rc(6'h0a, ro(1));
      // no-acknowledge sets the bus error until the status is read
      @(posedge clk) nack <= 1'b1;
      @(posedge clk) nack <= 1'b0;
      rc(6'h04, 16'h0080);
      rc(6'h04, 16'h0000);
      // device reset self-clears and restores defaults
      wr(6'h05, 16'h0017, 1'b0);
      rd(6'h05);
      chk({15'h0, d[0]}, 16'h0001);
      repeat (6) @(posedge clk);
      rc(6'h05, 16'h0000);
      rc(6'h09, 16'h0007);
      // clock enable low: a control write in that cycle is not taken
      @(posedge clk) begin
         ce  <= 1'b0;
         req <= '{wr: 1'b1, rd: 1'b0, broadcast: 1'b0, addr: 6'h05, wdata: 16'h0010};
      end
      @(posedge clk) begin
         ce     <= 1'b1;
         req.wr <= 1'b0;
      end
      rc(6'h05, 16'h0000);
      finish_test;
   end
   // watchdog well beyond the fewer than a thousand cycles the sequence needs
   initial begin
      repeat (8000) @(posedge clk);
      err_count++;
      finish_test;
   end
endmodule : tb_top
`default_nettype wire
